// ==== inc/crsup_pkg.sv ====
package crsup_pkg;

    // clock rate and documented times
    localparam int unsigned CRSUP_CLK_HZ          = 50_000_000;
    localparam int unsigned CRSUP_CLK_PERIOD_NS   = 20;
    localparam int unsigned CRSUP_HOLD_MS         = 200;
    localparam int unsigned CRSUP_WDOG_MS         = 1600;
    localparam int unsigned CRSUP_GLITCH_NS       = 100;

    // derived cycle counts: hold and timeout are typical figures, glitch rounds up
    localparam int unsigned CRSUP_HOLD_CYCLES   = (CRSUP_CLK_HZ / 1000) * CRSUP_HOLD_MS;
    localparam int unsigned CRSUP_WDOG_CYCLES   = (CRSUP_CLK_HZ / 1000) * CRSUP_WDOG_MS;
    localparam int unsigned CRSUP_GLITCH_CYCLES =
        (CRSUP_GLITCH_NS + CRSUP_CLK_PERIOD_NS - 1) / CRSUP_CLK_PERIOD_NS;

    // width of the shared counters
    localparam int unsigned CRSUP_CNT_W = 32;

    // synchroniser reset values, low and high
    localparam logic [1:0] CRSUP_SYNC_RST_LOW  = 2'h0;
    localparam logic [1:0] CRSUP_SYNC_RST_HIGH = 2'h3;

    // synchronised inputs travel together
    typedef struct packed {
        logic supply_low;
        logic manual_reset_n;
        logic kick;
        logic kick_enable;
    } crsup_in_t;

    // sequencer states
    typedef enum logic [1:0] {
        CRSUP_ST_ACTIVE,
        CRSUP_ST_HOLD,
        CRSUP_ST_RUN
    } crsup_state_t;

endpackage : crsup_pkg

// ==== src/crsup_sync.sv ====
`timescale 1ns/10ps
// two-flop synchroniser for one input level
module crsup_sync
    import crsup_pkg::*;
#(
    parameter logic RST_VAL = 1'b0
)
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic d_in,
    output logic      q_out
);

    logic meta_reg;
    logic meta_next;
    logic sync_reg;
    logic sync_next;

    // first flop only feeds second
    always_comb
    begin
        meta_next = d_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
        end
        else
        begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign q_out = sync_reg;

endmodule : crsup_sync

// ==== src/crsup_top.sv ====
`timescale 1ns/10ps
// How it works
// - reset low while supply low
// - hold reset 200 ms after any release
// - manual reset low forces reset
// - hold starts on manual reset rising
// - kick stuck one timeout causes reset
// - watchdog disabled when kick floats
// - watchdog counter clears on reset, kick edges
// - high output is exact complement
// - manual reset pulses under 100 ns ignored
// - floating kick never trips watchdog
module crsup_top
    import crsup_pkg::*;
#(
    parameter bit                     HAS_MANUAL = 1'b1,
    parameter bit                     HAS_WDOG   = 1'b1,
    parameter bit                     HAS_HIGH   = 1'b1,
    parameter logic [CRSUP_CNT_W-1:0] HOLD_CYCLES   = CRSUP_CNT_W'(CRSUP_HOLD_CYCLES),
    parameter logic [CRSUP_CNT_W-1:0] WDOG_CYCLES   = CRSUP_CNT_W'(CRSUP_WDOG_CYCLES),
    parameter logic [CRSUP_CNT_W-1:0] GLITCH_CYCLES = CRSUP_CNT_W'(CRSUP_GLITCH_CYCLES)
)
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic supply_low_in,
    input  wire logic manual_reset_in_n,
    input  wire logic watchdog_kick_in,
    input  wire logic watchdog_kick_driven_in,
    output logic      cpu_reset_out_n,
    output logic      cpu_reset_out
);

    crsup_in_t                  sync_in;
    crsup_state_t               state_reg;
    crsup_state_t               state_next;
    logic [CRSUP_CNT_W-1:0]     hold_cnt_reg;
    logic [CRSUP_CNT_W-1:0]     hold_cnt_next;
    logic [CRSUP_CNT_W-1:0]     wdog_cnt_reg;
    logic [CRSUP_CNT_W-1:0]     wdog_cnt_next;
    logic [CRSUP_CNT_W-1:0]     glitch_cnt_reg;
    logic [CRSUP_CNT_W-1:0]     glitch_cnt_next;
    logic                       manual_low_reg;
    logic                       manual_low_next;
    logic                       kick_last_reg;
    logic                       kick_last_next;
    logic                       rst_n_reg;
    logic                       rst_n_next;
    logic                       rst_p_reg;
    logic                       rst_p_next;
    logic                       kick_edge;
    logic                       wdog_on;
    logic                       wdog_expire;
    logic                       source_active;

    // input synchronisers
    crsup_sync #(.RST_VAL(CRSUP_SYNC_RST_HIGH[0])) u_sync_supply
    (
        .sys_clk (sys_clk),
        .rst     (rst),
        .d_in    (supply_low_in),
        .q_out   (sync_in.supply_low)
    );
    crsup_sync #(.RST_VAL(CRSUP_SYNC_RST_HIGH[0])) u_sync_manual
    (
        .sys_clk (sys_clk),
        .rst     (rst),
        .d_in    (manual_reset_in_n | ~HAS_MANUAL),
        .q_out   (sync_in.manual_reset_n)
    );
    crsup_sync #(.RST_VAL(CRSUP_SYNC_RST_LOW[0])) u_sync_kick
    (
        .sys_clk (sys_clk),
        .rst     (rst),
        .d_in    (watchdog_kick_in),
        .q_out   (sync_in.kick)
    );
    crsup_sync #(.RST_VAL(CRSUP_SYNC_RST_LOW[0])) u_sync_kick_en
    (
        .sys_clk (sys_clk),
        .rst     (rst),
        .d_in    (watchdog_kick_driven_in & HAS_WDOG),
        .q_out   (sync_in.kick_enable)
    );

    // watchdog and sources
    always_comb
    begin
        kick_edge     = sync_in.kick ^ kick_last_reg;
        wdog_on       = sync_in.kick_enable;
        wdog_expire   = wdog_on && (wdog_cnt_reg >= WDOG_CYCLES - 1'b1);
        source_active = sync_in.supply_low || manual_low_reg;
    end

    // manual reset filter: low must persist past the glitch time
    always_comb
    begin
        glitch_cnt_next = '0;
        manual_low_next = manual_low_reg;
        if (sync_in.manual_reset_n)
        begin
            manual_low_next = 1'b0;
        end
        else if (glitch_cnt_reg >= GLITCH_CYCLES - 1'b1)
        begin
            glitch_cnt_next = glitch_cnt_reg;
            manual_low_next = 1'b1;
        end
        else
        begin
            glitch_cnt_next = glitch_cnt_reg + 1'b1;
        end
    end

    // sequencer: active, hold, run
    always_comb
    begin
        state_next    = state_reg;
        hold_cnt_next = hold_cnt_reg;
        case (state_reg)
            CRSUP_ST_ACTIVE:
            begin
                hold_cnt_next = '0;
                if (!source_active)
                begin
                    state_next = CRSUP_ST_HOLD;
                end
            end
            CRSUP_ST_HOLD:
            begin
                if (source_active)
                begin
                    state_next    = CRSUP_ST_ACTIVE;
                    hold_cnt_next = '0;
                end
                else if (hold_cnt_reg >= HOLD_CYCLES - 1'b1)
                begin
                    state_next = CRSUP_ST_RUN;
                end
                else
                begin
                    hold_cnt_next = hold_cnt_reg + 1'b1;
                end
            end
            CRSUP_ST_RUN:
            begin
                if (source_active)
                begin
                    state_next = CRSUP_ST_ACTIVE;
                end
                else if (wdog_expire)
                begin
                    state_next    = CRSUP_ST_HOLD;
                    hold_cnt_next = '0;
                end
            end
            default:
            begin
                state_next    = CRSUP_ST_ACTIVE;
                hold_cnt_next = '0;
            end
        endcase
    end

    // watchdog counter and outputs
    always_comb
    begin
        kick_last_next = sync_in.kick;
        if (state_reg != CRSUP_ST_RUN || kick_edge || !wdog_on || wdog_expire)
        begin
            wdog_cnt_next = '0;
        end
        else
        begin
            wdog_cnt_next = wdog_cnt_reg + 1'b1;
        end
        rst_n_next = (state_next == CRSUP_ST_RUN);
        rst_p_next = HAS_HIGH ? (state_next != CRSUP_ST_RUN) : 1'b0;
    end

    // register the manual filter and watchdog state
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wdog_cnt_reg   <= '0;
            glitch_cnt_reg <= '0;
            manual_low_reg <= 1'b0;
            kick_last_reg  <= 1'b0;
        end
        else
        begin
            wdog_cnt_reg   <= wdog_cnt_next;
            glitch_cnt_reg <= glitch_cnt_next;
            manual_low_reg <= manual_low_next;
            kick_last_reg  <= kick_last_next;
        end
    end

    // register the sequencer and both reset outputs; the high output idles at 0 when absent
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg      <= CRSUP_ST_ACTIVE;
            hold_cnt_reg   <= '0;
            rst_n_reg      <= 1'b0;
            rst_p_reg      <= HAS_HIGH;
        end
        else
        begin
            state_reg      <= state_next;
            hold_cnt_reg   <= hold_cnt_next;
            rst_n_reg      <= rst_n_next;
            rst_p_reg      <= rst_p_next;
        end
    end

    assign cpu_reset_out_n = rst_n_reg;
    assign cpu_reset_out   = rst_p_reg;

endmodule : crsup_top

// ==== bench/crsup_sva.sv ====
`timescale 1ns/10ps
// port checker for the reset supervisor
module crsup_sva
    import crsup_pkg::*;
#(
    parameter int HOLD_CYCLES = 20,
    parameter int WDOG_CYCLES = 50
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic supply_low_in,
    input wire logic manual_reset_in_n,
    input wire logic watchdog_kick_in,
    input wire logic watchdog_kick_driven_in,
    input wire logic cpu_reset_out_n,
    input wire logic cpu_reset_out
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    int   held_reg;
    int   idle_reg;
    logic kick_reg;
    // held: reset cycles with sources clear; idle: running cycles since a kick edge
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            held_reg <= 0;
            idle_reg <= 0;
            kick_reg <= 1'h0;
        end
        else
        begin
            held_reg <= (cpu_reset_out_n || supply_low_in || !manual_reset_in_n) ? 0 : held_reg + 1;
            idle_reg <= (!cpu_reset_out_n || !watchdog_kick_driven_in || watchdog_kick_in != kick_reg) ? 0 : idle_reg + 1;
            kick_reg <= watchdog_kick_in;
        end
    end
    a_high_complement: assert property (cpu_reset_out == !cpu_reset_out_n)
        else $error("high output not the complement");
    a_supply_reset: assert property (supply_low_in [*5] |-> !cpu_reset_out_n)
        else $error("supply low without reset");
    a_manual_reset: assert property (!manual_reset_in_n [*8] |-> ##2 !cpu_reset_out_n)
        else $error("manual low without reset");
    a_glitch_ignored: assert property (cpu_reset_out_n && !supply_low_in && $fell(manual_reset_in_n)
        ##1 !manual_reset_in_n [*2] ##1 manual_reset_in_n |-> cpu_reset_out_n [*8])
        else $error("short manual pulse caused reset");
    a_sync_latency: assert property ($rose(supply_low_in) && cpu_reset_out_n |=> cpu_reset_out_n)
        else $error("supply input used unsynchronised");
    a_hold_length: assert property ($rose(cpu_reset_out_n) |->
        held_reg inside {[HOLD_CYCLES - 2:HOLD_CYCLES + 6]})
        else $error("hold period wrong length");
    a_hold_bounded: assert property (held_reg <= HOLD_CYCLES + 6)
        else $error("reset never released");
    a_wdog_expiry: assert property (idle_reg <= WDOG_CYCLES + 4)
        else $error("stuck kick without reset");
    a_float_no_trip: assert property ((cpu_reset_out_n && !supply_low_in && manual_reset_in_n
        && !watchdog_kick_driven_in) [*4] |=> cpu_reset_out_n)
        else $error("floating kick caused reset");
    c_release: cover property ($rose(cpu_reset_out_n));
    c_wdog_near: cover property (idle_reg == WDOG_CYCLES - 6);
    c_floating: cover property (!watchdog_kick_driven_in && cpu_reset_out_n);
endmodule : crsup_sva

bind crsup_top crsup_sva #(.HOLD_CYCLES(HOLD_CYCLES), .WDOG_CYCLES(WDOG_CYCLES)) u_sva (.sys_clk, .rst,
    .supply_low_in, .manual_reset_in_n, .watchdog_kick_in, .watchdog_kick_driven_in, .cpu_reset_out_n, .cpu_reset_out);

// ==== bench/crsup_host.sv ====
`timescale 1ns/10ps
// host side: kicks the watchdog while out of reset, may let the line float
module crsup_host
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       cpu_reset_out_n,
    input  wire logic       kick_on,
    input  wire logic       drive_on,
    input  wire logic [7:0] kick_period,
    output logic            watchdog_kick_in,
    output logic            watchdog_kick_driven_in
);
    logic [7:0] tick_reg;
    logic       level_reg;
    logic       run;
    assign run = cpu_reset_out_n && kick_on && drive_on;
    // toggle the kick level every kick_period cycles while running
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            tick_reg  <= 8'h00;
            level_reg <= 1'h0;
        end
        else if (run && tick_reg >= kick_period - 8'h01)
        begin
            tick_reg  <= 8'h00;
            level_reg <= ~level_reg;
        end
        else
            tick_reg <= run ? tick_reg + 8'h01 : 8'h00;
    end
    // a released line shows the inverse of the last driven level
    assign watchdog_kick_in        = drive_on ? level_reg : ~level_reg;
    assign watchdog_kick_driven_in = drive_on;
endmodule : crsup_host

// ==== bench/tb.sv ====
`timescale 1ns/10ps
module tb;
    import crsup_pkg::*;
    logic       sys_clk = 1'h0;
    logic       rst = 1'h1;
    logic       supply_low_in = 1'h0;
    logic       manual_reset_in_n = 1'h1;
    logic       kick_on = 1'h1;
    logic       drive_on = 1'h1;
    logic [7:0] kick_period = 8'h0a;
    logic       watchdog_kick_in;
    logic       watchdog_kick_driven_in;
    logic       cpu_reset_out_n;
    logic       cpu_reset_out;
    int         mismatches = 0;
    int         total_checks = 0;
    // rows: {supply low, manual reset}, cycles to wait, expected reset_n
    logic [1:0] row_in [8] = '{2'h1, 2'h3, 2'h3, 2'h1, 2'h1, 2'h0, 2'h1, 2'h1};
    int         row_wait [8] = '{30, 4, 50, 18, 10, 10, 18, 10};
    logic       row_exp [8] = '{1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1};
    crsup_top #(.HOLD_CYCLES(32'h0000_0014), .WDOG_CYCLES(32'h0000_0032), .GLITCH_CYCLES(32'h0000_0005)) DUT (
        .sys_clk, .rst, .supply_low_in, .manual_reset_in_n, .watchdog_kick_in,
        .watchdog_kick_driven_in, .cpu_reset_out_n, .cpu_reset_out);
    crsup_host u_host (.sys_clk, .rst, .cpu_reset_out_n, .kick_on, .drive_on, .kick_period,
        .watchdog_kick_in, .watchdog_kick_driven_in);
    initial forever #10 sys_clk = ~sys_clk;
    // wait n cycles, then compare both reset outputs
    task automatic wait_check(input int n, input logic exp_n);
        repeat (n) @(posedge sys_clk);
        #1;
        total_checks++;
        if ({cpu_reset_out_n, cpu_reset_out} !== {exp_n, ~exp_n})
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, {cpu_reset_out_n, cpu_reset_out}, {exp_n, ~exp_n});
        end
    endtask : wait_check
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    // main sequence
    initial
    begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'h0;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge sys_clk);
            {supply_low_in, manual_reset_in_n} <= row_in[i];
            wait_check(row_wait[i], row_exp[i]);
        end
        // three-cycle manual pulse stays under the debounce span
        @(posedge sys_clk);
        manual_reset_in_n <= 1'h0;
        repeat (3) @(posedge sys_clk);
        manual_reset_in_n <= 1'h1;
        wait_check(20, 1'h1);
        // slow kicks just inside the timeout
        @(posedge sys_clk);
        kick_period <= 8'h2d;
        wait_check(150, 1'h1);
        // stop right after an edge: reset follows one timeout later
        @(watchdog_kick_in);
        @(posedge sys_clk);
        kick_on <= 1'h0;
        wait_check(43, 1'h1);
        wait_check(16, 1'h0);
        @(posedge sys_clk);
        kick_on <= 1'h1;
        kick_period <= 8'h0a;
        wait_check(30, 1'h1);
        // floating kick line leaves the watchdog off
        @(posedge sys_clk);
        drive_on <= 1'h0;
        wait_check(150, 1'h1);
        @(posedge sys_clk);
        drive_on <= 1'h1;
        rst <= 1'h1;
        wait_check(2, 1'h0);
        @(posedge sys_clk);
        rst <= 1'h0;
        wait_check(30, 1'h1);
        print_verdict();
    end
    // cut a hang short
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        print_verdict();
    end
endmodule : tb
